// ===== core/ghs_fifo.sv
// Purpose: small fifo, valid/ready on both sides
// Assumes: single clock; DEPTH a power of two
// Notes:   storage in flip-flops; level shows current fill
`timescale 1ns/1ps
module ghs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // fill side
  input  wire logic                         in_valid,
  input  wire logic [WIDTH-1:0]             in_data,
  output      logic                         in_ready,
  // drain side
  output      logic                         out_valid,
  output      logic [WIDTH-1:0]             out_data,
  input  wire logic                         out_ready,
  output      logic [$clog2(DEPTH+1)-1:0]   level
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic             push;
  logic             pop;

  assign in_ready  = (level != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= rd_idx + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end

endmodule

// ===== core/ghs_top.sv
// Purpose: host serial ports and second pulse behind APB
// Assumes: pclk 250 MHz; utc_second_mark and fix_valid come from logic on pclk
// Notes:   live port settings model the battery-backed copy, nv_* the non-volatile copy
`timescale 1ns/1ps

// Summary of operation
// - second_pulse is high ten microseconds once every second
// - rising edge of second_pulse is realigned to each utc second mark
// - accuracy flag and realignment only while valid fixes are reported
// - serial lines are non-inverted logic levels, idle high
// - port settings are kept in a non-volatile copy that survives power loss; here presetn resets the nv copy to factory values
// - port 1 factory setting: binary protocol, 9600 baud, 8 odd 1
// - port 2 factory setting: correction in, nmea out, 4800 baud, 8 none 1
// - protocol, baud and parity of each port are set independently
// - runtime settings live in the battery copy; saved to non-volatile on command
// - ports serve commands straight after reset, no acquisition wait
// - binary reports go out automatically or only in reply to a query
// - ascii protocol defaults on port 1: 4800 baud, 8 odd 1
// - nmea is output only, never accepted as an input protocol
module ghs_top #(
  parameter int unsigned BIT_CYC_BASE = ghs_pkg::CLK_HZ / ghs_pkg::BAUD_BASE,
  parameter int unsigned SEC_CYC      = ghs_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // navigation engine
  input  wire logic        utc_second_mark,
  input  wire logic        fix_valid,
  // pins
  input  wire logic [1:0]  serial_rx,
  output      logic [1:0]  serial_tx,
  output      logic        second_pulse
);

  localparam int unsigned SEC_W = $clog2(SEC_CYC + 1);
  localparam int unsigned LVL_W = $clog2(ghs_pkg::FIFO_D + 1);

  // ==========================================================================
  // bus phase decode
  logic setup;
  logic access;
  logic wr_access;
  logic rd_access;

  assign setup     = psel & ~penable;
  assign access    = psel & penable & pready;
  assign wr_access = access & pwrite;
  assign rd_access = access & ~pwrite;

  // ==========================================================================
  // commands
  logic cmd_wr;
  logic cmd_save;
  logic cmd_factory;
  logic cmd_ascii1;
  logic boot_load;

  assign cmd_wr      = wr_access && (paddr == ghs_pkg::CMD_OFF);
  assign cmd_save    = cmd_wr & pwdata[ghs_pkg::CMD_SAVE_BIT];
  assign cmd_factory = cmd_wr & pwdata[ghs_pkg::CMD_FACTORY_BIT];
  assign cmd_ascii1  = cmd_wr & pwdata[ghs_pkg::CMD_ASCII1_BIT];

  // reload live copy from the nv copy after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_load <= 1'b1;
    end else begin
      boot_load <= 1'b0;
    end
  end

  // ==========================================================================
  // per-port state seen by the register decode
  ghs_pkg::ghs_cfg_t live_cfg [ghs_pkg::NPORT];
  ghs_pkg::ghs_cfg_t nv_cfg   [ghs_pkg::NPORT];
  ghs_pkg::ghs_rx_t  rx_hold  [ghs_pkg::NPORT];
  logic [1:0]        fifo_full;
  logic [1:0]        fifo_empty;
  logic [1:0]        armed_q;

  genvar p;
  generate
    for (p = 0; p < ghs_pkg::NPORT; p++) begin : g_port
      localparam ghs_pkg::ghs_cfg_t FACTORY  = (p == 0) ? ghs_pkg::PORT1_FACTORY : ghs_pkg::PORT2_FACTORY;
      localparam logic [7:0]        CFG_OFF  = (p == 0) ? ghs_pkg::CFG1_OFF : ghs_pkg::CFG2_OFF;
      localparam logic [7:0]        DATA_OFF = (p == 0) ? ghs_pkg::DATA1_OFF : ghs_pkg::DATA2_OFF;

      ghs_pkg::ghs_cfg_t         cfg;
      ghs_pkg::ghs_cfg_t         nv;
      ghs_pkg::ghs_cfg_t         wcfg;
      ghs_pkg::ghs_cfg_t         next_cfg;
      ghs_pkg::ghs_rx_t          hold;
      logic                      cfg_wr;
      logic                      data_wr;
      logic                      data_rd;
      logic                      armed;
      logic                      tx_go;
      logic                      rx_en;
      logic                      rx_stb;
      logic [7:0]                rx_byte;
      logic                      rx_perr;
      logic                      rx_ferr;
      logic                      in_ready;
      logic                      out_valid;
      logic [7:0]                out_data;
      logic                      out_ready;
      logic                      uart_ready;
      logic [LVL_W-1:0]          level;
      logic [ghs_pkg::DIV_W-1:0] bit_cyc;

      assign cfg_wr  = wr_access && (paddr == CFG_OFF);
      assign data_wr = wr_access && (paddr == DATA_OFF) && in_ready;
      // only a read that showed a byte pops it;
      // a later arrival waits for the next read
      assign data_rd = rd_access && (paddr == DATA_OFF) && prdata[8];
      assign wcfg    = ghs_pkg::ghs_cfg_t'(pwdata[ghs_pkg::CFG_W-1:0]);
      assign rx_en   = (cfg.proto_in != ghs_pkg::PROTO_OFF);
      assign tx_go   = (cfg.proto_out != ghs_pkg::PROTO_OFF) && (cfg.auto_report || armed);
      assign bit_cyc = (ghs_pkg::DIV_W)'(BIT_CYC_BASE) >> cfg.baud;

      // illegal or refused codes leave the old field in place
      always_comb begin
        next_cfg = wcfg;
        if (wcfg.proto_in >= ghs_pkg::PROTO_NMEA) begin
          next_cfg.proto_in = cfg.proto_in;
        end
        if (wcfg.proto_out == ghs_pkg::PROTO_CORRECTION || wcfg.proto_out > ghs_pkg::PROTO_NMEA) begin
          next_cfg.proto_out = cfg.proto_out;
        end
        if (wcfg.parity > ghs_pkg::PAR_EVEN) begin
          next_cfg.parity = cfg.parity;
        end
      end

      // battery-backed live settings
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg <= FACTORY;
        end else if (boot_load) begin
          cfg <= nv;
        end else if (cmd_factory) begin
          cfg <= FACTORY;
        end else if (p == 0 && cmd_ascii1) begin
          cfg <= ghs_pkg::PORT1_ASCII;
        end else if (cfg_wr) begin
          cfg <= next_cfg;
        end
      end

      // nv copy changes only on save or factory restore
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          nv <= FACTORY;
        end else if (cmd_factory) begin
          nv <= FACTORY;
        end else if (cmd_save) begin
          nv <= cfg;
        end
      end

      // receive holder; arrival wins over a read
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold <= ghs_pkg::RX_RESET;
        end else if (rx_stb && rx_en) begin
          hold.data       <= rx_byte;
          hold.valid      <= 1'b1;
          hold.parity_err <= rx_perr;
          hold.frame_err  <= rx_ferr;
          hold.overrun    <= hold.overrun | (hold.valid & ~data_rd);
        end else if (data_rd) begin
          hold <= ghs_pkg::RX_RESET;
        end
      end

      // query mode: a received character releases replies
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          armed <= 1'b0;
        end else if (rx_stb && rx_en) begin
          armed <= 1'b1;
        end else if (out_valid && out_ready && level == (LVL_W)'(1)) begin
          armed <= 1'b0;
        end
      end

      assign out_ready = uart_ready & tx_go;

      ghs_fifo #(
        .WIDTH (8),
        .DEPTH (ghs_pkg::FIFO_D)
      ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (data_wr),
        .in_data   (pwdata[7:0]),
        .in_ready  (in_ready),
        .out_valid (out_valid),
        .out_data  (out_data),
        .out_ready (out_ready),
        .level     (level)
      );

      ghs_uart u_uart (
        .clk      (pclk),
        .rst_n    (presetn),
        .bit_cyc  (bit_cyc),
        .parity   (cfg.parity),
        .stop2    (cfg.stop2),
        .tx_valid (out_valid & tx_go),
        .tx_data  (out_data),
        .tx_ready (uart_ready),
        .rx_valid (rx_stb),
        .rx_data  (rx_byte),
        .rx_perr  (rx_perr),
        .rx_ferr  (rx_ferr),
        .rx_pin   (serial_rx[p]),
        .tx_pin   (serial_tx[p])
      );

      assign live_cfg[p]   = cfg;
      assign nv_cfg[p]     = nv;
      assign rx_hold[p]    = hold;
      assign fifo_full[p]  = ~in_ready;
      assign fifo_empty[p] = ~out_valid;
      assign armed_q[p]    = armed;
    end
  endgenerate

  // ==========================================================================
  // second pulse
  logic [SEC_W-1:0] sec_cnt;
  logic [SEC_W-1:0] next_sec_cnt;
  logic             accurate;

  always_comb begin
    if (utc_second_mark && fix_valid) begin
      next_sec_cnt = '0;
    end else if (sec_cnt == (SEC_W)'(SEC_CYC - 1)) begin
      next_sec_cnt = '0;
    end else begin
      next_sec_cnt = sec_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt <= (SEC_W)'(SEC_CYC - 1);
    end else begin
      sec_cnt <= next_sec_cnt;
    end
  end

  // host must time from the rising edge; the fall is just the width count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_pulse <= 1'b0;
    end else begin
      second_pulse <= (next_sec_cnt < (SEC_W)'(ghs_pkg::PULSE_CYC));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accurate <= 1'b0;
    end else begin
      accurate <= fix_valid;
    end
  end

  // ==========================================================================
  // register read and error decode, taken in the setup cycle
  logic [31:0] next_prdata;
  logic        next_err;
  logic        sel_port;

  assign sel_port = paddr[2];

  always_comb begin
    next_prdata = '0;
    next_err    = 1'b0;
    unique case (paddr)
      ghs_pkg::CFG1_OFF, ghs_pkg::CFG2_OFF: begin
        next_prdata = 32'(live_cfg[sel_port]);
      end
      ghs_pkg::CMD_OFF: begin
        next_prdata = '0;
      end
      ghs_pkg::STATUS_OFF: begin
        next_prdata = {22'h0, armed_q, rx_hold[1].valid, rx_hold[0].valid, fifo_empty, fifo_full,
                       second_pulse, accurate};
      end
      ghs_pkg::DATA1_OFF, ghs_pkg::DATA2_OFF: begin
        next_prdata = 32'(rx_hold[sel_port]);
        // a write into a full transmit buffer is refused
        next_err    = pwrite & fifo_full[sel_port];
      end
      ghs_pkg::NV1_OFF, ghs_pkg::NV2_OFF: begin
        next_prdata = 32'(nv_cfg[sel_port]);
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= next_prdata;
        pslverr <= next_err;
      end
    end
  end

endmodule

// ===== core/ghs_uart.sv
// Purpose: one serial port, 8 data bits
// Assumes: bit_cyc stable for a whole frame; rx_pin asynchronous to clk
// Notes:   frame settings are taken at the start of each character
`timescale 1ns/1ps
module ghs_uart (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // frame settings
  input  wire logic [ghs_pkg::DIV_W-1:0] bit_cyc,
  input  wire ghs_pkg::ghs_par_t        parity,
  input  wire logic                     stop2,
  // transmit stream
  input  wire logic                     tx_valid,
  input  wire logic [7:0]               tx_data,
  output      logic                     tx_ready,
  // receive result
  output      logic                     rx_valid,
  output      logic [7:0]               rx_data,
  output      logic                     rx_perr,
  output      logic                     rx_ferr,
  // pins
  input  wire logic                     rx_pin,
  output      logic                     tx_pin
);

  // ==========================================================================
  // transmitter
  logic                      tx_busy;
  logic [10:0]               tx_shift;
  logic [3:0]                tx_left;
  logic [ghs_pkg::DIV_W-1:0] tx_cnt;
  logic                      has_par;
  logic                      par_bit;

  assign has_par  = (parity != ghs_pkg::PAR_NONE);
  assign par_bit  = (parity == ghs_pkg::PAR_ODD) ? ~^tx_data : ^tx_data;
  assign tx_ready = ~tx_busy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy  <= 1'b0;
      tx_shift <= '1;
      tx_left  <= '0;
      tx_cnt   <= '0;
      tx_pin   <= 1'b1;
    end else if (!tx_busy) begin
      if (tx_valid) begin
        tx_busy  <= 1'b1;
        tx_pin   <= 1'b0;
        tx_shift <= has_par ? {2'b11, par_bit, tx_data} : {3'b111, tx_data};
        tx_left  <= 4'd9 + {3'b000, has_par} + {3'b000, stop2};
        tx_cnt   <= bit_cyc - 1'b1;
      end
    end else if (tx_cnt != '0) begin
      tx_cnt <= tx_cnt - 1'b1;
    end else if (tx_left != '0) begin
      tx_pin   <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_left  <= tx_left - 1'b1;
      tx_cnt   <= bit_cyc - 1'b1;
    end else begin
      tx_busy <= 1'b0;
    end
  end

  // ==========================================================================
  // receiver: sample near the middle of each bit
  logic                      rx_s1;
  logic                      rx_s2;
  logic                      rx_busy;
  logic                      rx_par;
  ghs_pkg::ghs_par_t         rx_kind;
  logic [10:0]               rx_shift;
  logic [3:0]                rx_left;
  logic [ghs_pkg::DIV_W-1:0] rx_cnt;
  logic [10:0]               next_shift;
  logic [10:0]               frame;
  logic                      exp_par;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
    end
  end

  always_comb begin
    next_shift = {rx_s2, rx_shift[10:1]};
    frame      = rx_par ? next_shift : {1'b0, next_shift[10:1]};
    exp_par    = (rx_kind == ghs_pkg::PAR_ODD) ? ~^frame[8:1] : ^frame[8:1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy  <= 1'b0;
      rx_par   <= 1'b0;
      rx_kind  <= ghs_pkg::PAR_NONE;
      rx_shift <= '0;
      rx_left  <= '0;
      rx_cnt   <= '0;
      rx_valid <= 1'b0;
      rx_data  <= '0;
      rx_perr  <= 1'b0;
      rx_ferr  <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s2) begin
          rx_busy  <= 1'b1;
          rx_par   <= has_par;
          rx_kind  <= parity;
          rx_shift <= '0;
          rx_left  <= 4'd10 + {3'b000, has_par};
          rx_cnt   <= bit_cyc >> 1;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_shift <= next_shift;
        rx_left  <= rx_left - 1'b1;
        rx_cnt   <= bit_cyc - 1'b1;
        if (rx_left == 4'd1) begin
          rx_busy  <= 1'b0;
          rx_valid <= 1'b1;
          rx_data  <= frame[8:1];
          rx_perr  <= rx_par & (frame[9] != exp_par);
          rx_ferr  <= frame[0] | ~(rx_par ? frame[10] : frame[9]);
        end
      end
    end
  end

endmodule

// ===== dv/ghs_asserts.sv
// Purpose: port checks on ghs_top
// Assumes: one clock, async reset
// Notes:   pulse width counted in helper logic
`timescale 1ns/1ps
module ghs_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins
  input wire logic       utc_second_mark,
  input wire logic       fix_valid,
  input wire logic [1:0] serial_tx,
  input wire logic       second_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // helpers
  logic [11:0] hi_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt <= '0;
    else
      hi_cnt <= second_pulse ? hi_cnt + 12'h001 : 12'h000;
  end
  pls_width_a: assert property ($fell(second_pulse) |-> hi_cnt == 12'(ghs_pkg::PULSE_CYC))
    else $error("pulse width");
  pls_align_a: assert property (utc_second_mark && fix_valid && !second_pulse |-> ##[1:2] second_pulse)
    else $error("no realign");
  rdy_after_a: assert property (psel && !penable |=> pready)
    else $error("no ready");
  rdy_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("stray ready");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("long ready");
  err_unmap_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr)
    else $error("unmapped accepted");
  start_p1_a: assert property ($fell(serial_tx[0]) |-> (serial_tx[0] == 1'b0) [*8])
    else $error("p1 start short");
  start_p2_a: assert property ($fell(serial_tx[1]) |-> (serial_tx[1] == 1'b0) [*8])
    else $error("p2 start short");
endmodule
bind ghs_top ghs_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .utc_second_mark(utc_second_mark),
  .fix_valid(fix_valid), .serial_tx(serial_tx), .second_pulse(second_pulse));

// ===== dv/ghs_host_model.sv
// Purpose: host serial controller on both ports
// Assumes: bit time in clk cycles given per call
// Notes:   lines idle high, odd parity when enabled
`timescale 1ns/1ps
module ghs_host_model (
  // clock
  input wire logic       clk,
  // lines
  input wire logic [1:0] tx_line,
  output     logic [1:0] rx_line
);
  initial rx_line = 2'b11;
  task automatic send(input int p, input logic [7:0] b, input logic par, input int bc);
    logic [10:0] fr;
    fr = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < (par ? 11 : 10); i++) begin
      rx_line[p] <= (!par && i == 9) ? 1'b1 : fr[i];
      repeat (bc) @(posedge clk);
    end
    rx_line[p] <= 1'b1;
  endtask
  task automatic get(input int p, input logic par, input int bc, output logic [7:0] b, output logic ok);
    logic [10:0] fr;
    int n;
    n = 0;
    while (tx_line[p] !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < (par ? 11 : 10); i++) begin
      fr[i] = tx_line[p];
      repeat (bc) @(posedge clk);
    end
    b = fr[8:1];
    ok = fr[0] === 1'b0 && (par ? (fr[10] === 1'b1 && ^fr[9:1] === 1'b1) : fr[9] === 1'b1);
  endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for ghs_top
// Assumes: bit base 64 cycles, second 10000 cycles
// Notes:   host model plays the far side
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        utc_second_mark, fix_valid, second_pulse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  serial_rx, serial_tx;
  int          num_errors, cmp_count;
  ghs_top #(.BIT_CYC_BASE(64), .SEC_CYC(10000)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .utc_second_mark(utc_second_mark), .fix_valid(fix_valid), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .second_pulse(second_pulse));
  ghs_host_model i_host (.clk(pclk), .tx_line(serial_tx), .rx_line(serial_rx));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ====
  // shared tasks
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "read data");
    chk({31'h0, e}, 32'h0, "read error");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, xe}, "write error");
  endtask
  // ====
  // scenarios
  task automatic t_cfg;
    rd(ghs_pkg::CFG1_OFF, 32'h925);
    rd(ghs_pkg::CFG2_OFF, 32'hc60);
    rd(ghs_pkg::NV2_OFF, 32'hc60);
    wr(8'h20, 32'h0, 1'b1);
    wr(ghs_pkg::CFG2_OFF, 32'hc80, 1'b0);
    rd(ghs_pkg::CFG2_OFF, 32'hc60);
    wr(ghs_pkg::CFG1_OFF, 32'h126, 1'b0);
    rd(ghs_pkg::CFG1_OFF, 32'h126);
    rd(ghs_pkg::CFG2_OFF, 32'hc60);
    rd(ghs_pkg::NV1_OFF, 32'h925);
    wr(ghs_pkg::CMD_OFF, 32'h1, 1'b0);
    rd(ghs_pkg::NV1_OFF, 32'h126);
    wr(ghs_pkg::CMD_OFF, 32'h4, 1'b0);
    rd(ghs_pkg::CFG1_OFF, 32'ha44);
    wr(ghs_pkg::CMD_OFF, 32'h2, 1'b0);
    rd(ghs_pkg::NV1_OFF, 32'h925);
    $display("config test done");
  endtask
  task automatic t_serial(input int p, input logic [7:0] d, input logic par, input int bc);
    logic [7:0] b;
    logic [7:0] a;
    logic       ok;
    a = p ? ghs_pkg::DATA2_OFF : ghs_pkg::DATA1_OFF;
    fork
      wr(a, {24'h0, d}, 1'b0);
      i_host.get(p, par, bc, b, ok);
    join
    chk({24'h0, b}, {24'h0, d}, "tx byte");
    chk({31'h0, ok}, 32'h1, "tx frame");
    i_host.send(p, ~d, par, bc);
    repeat (8) @(posedge pclk);
    rd(a, {23'h0, 1'b1, ~d});
    $display("serial test done");
  endtask
  task automatic t_fill;
    logic [31:0] r;
    logic        e;
    logic [7:0]  b;
    logic        ok;
    // tx off: the earlier rx left port 2 armed
    wr(ghs_pkg::CFG2_OFF, 32'h060, 1'b0);
    for (int i = 0; i < 9; i++)
      wr(ghs_pkg::DATA2_OFF, i, i == 8);
    apb(1'b0, ghs_pkg::STATUS_OFF, 32'h0, r, e);
    chk({31'h0, r[3]}, 32'h1, "fifo full");
    fork
      wr(ghs_pkg::CFG2_OFF, 32'hc60, 1'b0);
      i_host.get(1, 1'b0, 64, b, ok);
    join
    chk({24'h0, b}, 32'h0, "first queued byte");
    $display("fill test done");
  endtask
  task automatic t_pulse;
    int n;
    n = 0;
    while (second_pulse !== 1'b0 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    repeat (100) @(posedge pclk);
    fix_valid       <= 1'b1;
    utc_second_mark <= 1'b1;
    @(posedge pclk);
    utc_second_mark <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, second_pulse}, 32'h1, "pulse rise");
    repeat (3000) @(posedge pclk);
    fix_valid       <= 1'b0;
    utc_second_mark <= 1'b1;
    @(posedge pclk);
    utc_second_mark <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, second_pulse}, 32'h0, "no fix no pulse");
    $display("pulse test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, utc_second_mark, fix_valid} = 6'h00;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    num_errors = 0;
    cmp_count  = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_cfg();
    t_serial(0, 8'ha5, 1'b1, 32);
    t_serial(1, 8'h3c, 1'b0, 64);
    t_fill();
    t_pulse();
    end_of_test();
  end
endmodule

// ===== include/ghs_pkg.sv
// Purpose: constants and types of the serial and pulse block
// Assumes: 250 MHz pclk; APB with 32-bit data; two serial ports
// Notes:   register offsets are byte addresses, one aligned word each
package ghs_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned CLK_MHZ   = 250;
  localparam int unsigned BAUD_BASE = 4800;
  localparam int unsigned PULSE_US  = 10;
  localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int unsigned DIV_W     = 17;
  localparam int unsigned NPORT     = 2;
  localparam int unsigned FIFO_D    = 8;

  // ==========================================================================
  // register map
  localparam logic [7:0] CFG1_OFF   = 8'h00;
  localparam logic [7:0] CFG2_OFF   = 8'h04;
  localparam logic [7:0] CMD_OFF    = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] DATA1_OFF  = 8'h10;
  localparam logic [7:0] DATA2_OFF  = 8'h14;
  localparam logic [7:0] NV1_OFF    = 8'h18;
  localparam logic [7:0] NV2_OFF    = 8'h1c;

  localparam int unsigned CMD_SAVE_BIT    = 0;
  localparam int unsigned CMD_FACTORY_BIT = 1;
  localparam int unsigned CMD_ASCII1_BIT  = 2;

  // ==========================================================================
  // field types
  typedef enum logic [1:0] {BAUD_4800, BAUD_9600, BAUD_19200, BAUD_38400} ghs_baud_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} ghs_par_t;
  typedef enum logic [2:0] {PROTO_OFF, PROTO_BINARY, PROTO_ASCII, PROTO_CORRECTION, PROTO_NMEA} ghs_proto_t;

  typedef struct packed {
    logic       auto_report;
    ghs_proto_t proto_out;
    ghs_proto_t proto_in;
    logic       stop2;
    ghs_par_t   parity;
    ghs_baud_t  baud;
  } ghs_cfg_t;

  typedef struct packed {
    logic       overrun;
    logic       frame_err;
    logic       parity_err;
    logic       valid;
    logic [7:0] data;
  } ghs_rx_t;

  localparam int unsigned CFG_W = $bits(ghs_cfg_t);
  localparam int unsigned RX_W  = $bits(ghs_rx_t);

  // ==========================================================================
  // reset values and ascii preset
  localparam ghs_cfg_t PORT1_FACTORY = '{auto_report: 1'b1, proto_out: PROTO_BINARY, proto_in: PROTO_BINARY,
                                         stop2: 1'b0, parity: PAR_ODD, baud: BAUD_9600};
  localparam ghs_cfg_t PORT2_FACTORY = '{auto_report: 1'b1, proto_out: PROTO_NMEA, proto_in: PROTO_CORRECTION,
                                         stop2: 1'b0, parity: PAR_NONE, baud: BAUD_4800};
  localparam ghs_cfg_t PORT1_ASCII   = '{auto_report: 1'b1, proto_out: PROTO_ASCII, proto_in: PROTO_ASCII,
                                         stop2: 1'b0, parity: PAR_ODD, baud: BAUD_4800};
  localparam ghs_rx_t  RX_RESET      = '{overrun: 1'b0, frame_err: 1'b0, parity_err: 1'b0, valid: 1'b0,
                                         data: 8'h00};

endpackage
